// >>> rtl/list_sweep_pkg.sv
// shared constants and types for the list/sweep command engine
`default_nettype none
package list_sweep_pkg;
	// ==================================================
	// command address bytes
	localparam logic [7:0] CMD_REINIT      = 8'h01;
	localparam logic [7:0] CMD_ACTIVE      = 8'h02;
	localparam logic [7:0] CMD_GEN_SELECT  = 8'h05;
	localparam logic [7:0] CMD_LIST_CONFIG = 8'h06;
	localparam logic [7:0] CMD_START_FREQ  = 8'h07;
	localparam logic [7:0] CMD_STOP_FREQ   = 8'h08;
	localparam logic [7:0] CMD_STEP_FREQ   = 8'h09;
	localparam logic [7:0] CMD_DWELL       = 8'h0A;
	localparam logic [7:0] CMD_CYCLES      = 8'h0B;
	localparam logic [7:0] CMD_POINTS      = 8'h0C;
	localparam logic [7:0] CMD_BUF_WRITE   = 8'h0D;
	localparam logic [7:0] CMD_SOFT_TRIG   = 8'h0F;
	localparam logic [7:0] CMD_RF_FREQ     = 8'h10;
	localparam logic [7:0] CMD_GET_STATUS  = 8'h18;
	localparam logic [7:0] CMD_GET_PARAMS  = 8'h25;
	// ==================================================
	// data values and field positions
	localparam logic [63:0] BUF_END_MARK = 64'h0000_0000_FFFF_FFFF;
	localparam int CFG_SWEEP_BIT  = 0; // 1 = sweep, 0 = list
	localparam int CFG_DIR_BIT    = 1; // 1 = downward
	localparam int CFG_TRI_BIT    = 2; // triangle waveform
	localparam int CFG_HWTRIG_BIT = 3; // 1 = hardware trigger source
	localparam int CFG_STEPHW_BIT = 4; // step on each trigger
	localparam int CFG_RET_BIT    = 5; // return to start when done
	localparam int CFG_TOUT_BIT   = 6; // trigger out enable
	localparam int CFG_TOCYC_BIT  = 7; // trigger out per cycle
	// ==================================================
	// reset values
	localparam logic [63:0] DEF_FREQ  = 64'h0000_0000_3B9A_CA00;
	localparam logic [31:0] DEF_DWELL = 32'h0000_0002;
	localparam logic [7:0]  DEF_CFG   = 8'h00;
	// ==================================================
	// timing: dwell unit in us, system clock in MHz
	localparam int DWELL_UNIT_US = 500;
	localparam int CLK_MHZ       = 25;
	localparam int DWELL_UNIT_CYC = DWELL_UNIT_US * CLK_MHZ;
	// ==================================================
	// command carrier
	typedef struct packed {
		logic        valid; // one-cycle command strobe
		logic        isRead; // read request when set
		logic [7:0]  addr;  // command address byte
		logic [63:0] data;  // data or instruction word
	} cmd_s;
	typedef struct packed {
		logic        valid; // one-cycle answer strobe
		logic [63:0] data;  // received word
	} resp_s;
endpackage : list_sweep_pkg
`default_nettype wire

// >>> rtl/dwell_tick.sv
// dwell interval timer counting 500 us units
`default_nettype none
module dwell_tick
	import list_sweep_pkg::*;
#(
	parameter int UNIT_CYC = DWELL_UNIT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        reload,    // restart at a new point
	input  wire logic        run,       // count while high
	input  wire logic [31:0] units,     // dwell in units
	output logic             expired    // one-cycle pulse
);
	// ==================================================
	// counters
	logic [15:0] cycCnt_r, cycCnt_nxt;   // cycles in one unit
	logic [31:0] unitCnt_r, unitCnt_nxt; // units elapsed
	logic        exp_nxt;
	localparam logic [15:0] UNIT_LAST = 16'(UNIT_CYC - 1);

	// next-state of the timer
	always_comb begin
		cycCnt_nxt  = cycCnt_r;
		unitCnt_nxt = unitCnt_r;
		exp_nxt     = 1'b0;
		if (reload || !run) begin
			cycCnt_nxt  = '0;
			unitCnt_nxt = '0;
		end else if (cycCnt_r == UNIT_LAST) begin
			cycCnt_nxt = '0;
			if (unitCnt_r + 32'd1 >= units) begin
				unitCnt_nxt = '0;
				exp_nxt     = 1'b1;
			end else begin
				unitCnt_nxt = unitCnt_r + 32'd1;
			end
		end else begin
			cycCnt_nxt = cycCnt_r + 16'd1;
		end
	end

	// register the timer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cycCnt_r  <= '0;
			unitCnt_r <= '0;
			expired   <= 1'b0;
		end else begin
			cycCnt_r  <= cycCnt_nxt;
			unitCnt_r <= unitCnt_nxt;
			expired   <= exp_nxt;
		end
	end
endmodule // dwell_tick
`default_nettype wire

// >>> rtl/list_sweep_command_engine.sv
// command interpreter for a two-channel list/sweep source
// Overview of operation
// - open turns activity indicator on
// - close turns activity indicator off
// - write applies data word to addressed register
// - read returns word selected by instruction
// - reinit mode 0 restores power-up defaults except the indicator and, during a run, the tuning of active channels
// - reinit mode 1 keeps current settings
// - per-channel frequency command retunes channel unless a run is stepping it
// - per-channel fixed or sweep/list mode
// - list configuration steers sweep behaviour
// - separate start, stop, step frequencies
// - dwell per point in 500 us units
// - run programmed cycles then stop
// - zero cycles repeats forever
// - zero write resets position; other words except the end mark store
// - end mark sets point count, stores nothing
// - dwell register at address 0x0A
// - buffer writes at address 0x0D
// - soft trigger only with a channel in sweep/list, soft source
`default_nettype none
module list_sweep_command_engine
	import list_sweep_pkg::*;
#(
	parameter int DEPTH    = 64,
	parameter int IDX_W    = 6,
	parameter int UNIT_CYC = DWELL_UNIT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire list_sweep_pkg::cmd_s cmd,  // command from host path
	output list_sweep_pkg::resp_s     resp, // read answer
	output logic             activeLed,     // front panel indicator
	output logic [63:0]      ch0Freq,       // channel 0 tuning word
	output logic [63:0]      ch1Freq,       // channel 1 tuning word
	output logic [1:0]       channel_generation_select, // 1 = sweep/list
	output logic             listRunning,   // stepping in progress
	output logic             reinit_cmd     // logic reset pulse
);
	import list_sweep_pkg::*;

	// ==================================================
	// settings and state
	logic [63:0] startF_r, startF_nxt;  // sweep start
	logic [63:0] stopF_r, stopF_nxt;    // sweep stop
	logic [63:0] stepF_r, stepF_nxt;    // sweep step
	logic [31:0] dwell_r, dwell_nxt;    // dwell units
	logic [31:0] cycles_r, cycles_nxt;  // cycles to run
	logic [31:0] points_r, points_nxt;  // list points
	logic [7:0]  cfg_r, cfg_nxt;        // list behaviour
	logic [IDX_W-1:0] wrPos_r, wrPos_nxt; // buffer write counter
	logic [IDX_W-1:0] idx_r, idx_nxt;   // current list point
	logic [31:0] cycDone_r, cycDone_nxt; // cycles completed
	logic [63:0] curF_r, curF_nxt;      // current sweep point
	logic [63:0] f0_nxt, f1_nxt;
	logic [1:0]  gen_nxt;
	logic        led_nxt, run_nxt, reinit_nxt;
	resp_s       resp_nxt;
	logic        reload, expired, bufWe;
	logic [63:0] bufMem [DEPTH];        // list buffer RAM

	typedef enum logic [0:0] { IDLE, STEPPING } run_e;
	run_e st_r, st_nxt;

	// ==================================================
	// helpers
	function automatic logic wr(input cmd_s c, input logic [7:0] a);
		return c.valid && !c.isRead && c.addr == a;
	endfunction

	// dwell timer instance
	dwell_tick #(.UNIT_CYC(UNIT_CYC)) dwell_tick_inst (
		.clk_sys (clk_sys),
		.rst     (rst),
		.reload  (reload),
		.run     (st_r == STEPPING),
		.units   (dwell_r),
		.expired (expired)
	);

	// list buffer write port
	// buffer store
	assign bufWe = wr(cmd, CMD_BUF_WRITE) && cmd.data != '0
		&& cmd.data != BUF_END_MARK;
	always_ff @(posedge clk_sys) begin
		if (bufWe)
			bufMem[wrPos_r] <= cmd.data;
	end

	// ==================================================
	// command decode and sequencing
	always_comb begin
		logic trig;
		logic lastPt;
		logic sweepMode;
		trig      = 1'b0;
		lastPt    = 1'b0;
		sweepMode = cfg_r[CFG_SWEEP_BIT];
		startF_nxt = startF_r;
		stopF_nxt  = stopF_r;
		stepF_nxt  = stepF_r;
		dwell_nxt  = dwell_r;
		cycles_nxt = cycles_r;
		points_nxt = points_r;
		cfg_nxt    = cfg_r;
		wrPos_nxt  = wrPos_r;
		idx_nxt    = idx_r;
		cycDone_nxt = cycDone_r;
		curF_nxt   = curF_r;
		f0_nxt     = ch0Freq;
		f1_nxt     = ch1Freq;
		gen_nxt    = channel_generation_select;
		led_nxt    = activeLed;
		reinit_nxt = 1'b0;
		st_nxt     = st_r;
		reload     = 1'b0;
		resp_nxt   = '0;
		if (cmd.valid && !cmd.isRead) begin
			case (cmd.addr)
				CMD_ACTIVE: begin
					led_nxt = cmd.data[0];
				end
				CMD_REINIT: begin
					reinit_nxt = 1'b1;
					st_nxt = IDLE;
					if (cmd.data[0] == 1'b0) begin
						startF_nxt = DEF_FREQ;
						stopF_nxt  = DEF_FREQ;
						stepF_nxt  = '0;
						dwell_nxt  = DEF_DWELL;
						cycles_nxt = '0;
						points_nxt = '0;
						cfg_nxt    = DEF_CFG;
						wrPos_nxt  = '0;
						f0_nxt     = DEF_FREQ;
						f1_nxt     = DEF_FREQ;
						gen_nxt    = '0;
					end
				end
				CMD_RF_FREQ: begin
					if (cmd.data[63]) f1_nxt = {1'b0, cmd.data[62:0]};
					else f0_nxt = cmd.data;
				end
				CMD_GEN_SELECT: begin
					gen_nxt[cmd.data[8]] = cmd.data[0];
					if (!cmd.data[0]) st_nxt = IDLE;
				end
				CMD_LIST_CONFIG: cfg_nxt = cmd.data[7:0];
				CMD_START_FREQ: startF_nxt = cmd.data;
				CMD_STOP_FREQ:  stopF_nxt  = cmd.data;
				CMD_STEP_FREQ:  stepF_nxt  = cmd.data;
				CMD_DWELL:  dwell_nxt  = cmd.data[31:0];
				CMD_CYCLES: cycles_nxt = cmd.data[31:0];
				CMD_POINTS: points_nxt = cmd.data[31:0];
				CMD_BUF_WRITE: begin
					if (cmd.data == '0)
						wrPos_nxt = '0;
					else if (cmd.data == BUF_END_MARK)
						points_nxt = 32'(wrPos_r);
					else
						wrPos_nxt = wrPos_r + 1'b1;
				end
				CMD_SOFT_TRIG: trig = 1'b1;
				default: ;
			endcase
		end else if (cmd.valid && cmd.isRead) begin
			resp_nxt.valid = 1'b1;
			case (cmd.addr)
				CMD_GET_STATUS: resp_nxt.data = {46'd0,
					channel_generation_select, listRunning,
					activeLed, 6'd0, cfg_r};
				CMD_GET_PARAMS: case (cmd.data[2:0])
					3'd0: resp_nxt.data = ch0Freq;
					3'd1: resp_nxt.data = ch1Freq;
					3'd2: resp_nxt.data = startF_r;
					3'd3: resp_nxt.data = stopF_r;
					3'd4: resp_nxt.data = stepF_r;
					3'd5: resp_nxt.data = {32'd0, dwell_r};
					3'd6: resp_nxt.data = {32'd0, cycles_r};
					default: resp_nxt.data = {32'd0, points_r};
				endcase
				CMD_BUF_WRITE:
					resp_nxt.data = bufMem[cmd.data[IDX_W-1:0]];
				default: resp_nxt.data = '0;
			endcase
		end
		if (trig && !cfg_r[CFG_HWTRIG_BIT]
			&& channel_generation_select != 2'b00) begin
			if (st_r == IDLE) begin
				st_nxt = STEPPING;
				reload = 1'b1;
				idx_nxt = '0;
				cycDone_nxt = '0;
				// a downward sweep opens at the stop frequency
				curF_nxt = sweepMode ? (cfg_r[CFG_DIR_BIT]
					? stopF_r : startF_r) : bufMem[0];
			end
		end
		// stepping through points
		case (st_r)
			IDLE: ;
			STEPPING: begin
				if (sweepMode)
					lastPt = cfg_r[CFG_DIR_BIT]
						? (curF_r <= startF_r + stepF_r)
						: (curF_r + stepF_r >= stopF_r);
				else
					lastPt = 32'(idx_r) + 32'd1 >= points_r;
				if (expired) begin
					// timer restarts itself on expiry; a reload
					// here would stretch every point by a cycle
					if (lastPt) begin
						cycDone_nxt = cycDone_r + 32'd1;
						if (cycles_r != '0 && cycDone_r + 32'd1 >= cycles_r)
							st_nxt = IDLE;
						else begin
							idx_nxt = '0;
							curF_nxt = sweepMode ? (cfg_r[CFG_DIR_BIT]
								? stopF_r : startF_r) : bufMem[0];
						end
					end else if (sweepMode) begin
						curF_nxt = cfg_r[CFG_DIR_BIT]
							? curF_r - stepF_r : curF_r + stepF_r;
					end else begin
						idx_nxt = idx_r + 1'b1;
						curF_nxt = bufMem[idx_r + 1'b1];
					end
				end
			end
			default: st_nxt = IDLE;
		endcase
		// drive active channels with the sweep point
		if (st_r == STEPPING) begin
			if (channel_generation_select[0]) f0_nxt = curF_nxt;
			if (channel_generation_select[1]) f1_nxt = curF_nxt;
		end
		run_nxt = st_nxt == STEPPING;
	end

	// ==================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			startF_r <= DEF_FREQ;
			stopF_r  <= DEF_FREQ;
			stepF_r  <= '0;
			dwell_r  <= DEF_DWELL;
			cycles_r <= '0;
			points_r <= '0;
			cfg_r    <= DEF_CFG;
			wrPos_r  <= '0;
			idx_r    <= '0;
			cycDone_r <= '0;
			curF_r   <= DEF_FREQ;
			ch0Freq  <= DEF_FREQ;
			ch1Freq  <= DEF_FREQ;
			channel_generation_select <= '0;
			activeLed <= 1'b0;
			listRunning <= 1'b0;
			reinit_cmd <= 1'b0;
			resp     <= '0;
			st_r     <= IDLE;
		end else begin
			startF_r <= startF_nxt;
			stopF_r  <= stopF_nxt;
			stepF_r  <= stepF_nxt;
			dwell_r  <= dwell_nxt;
			cycles_r <= cycles_nxt;
			points_r <= points_nxt;
			cfg_r    <= cfg_nxt;
			wrPos_r  <= wrPos_nxt;
			idx_r    <= idx_nxt;
			cycDone_r <= cycDone_nxt;
			curF_r   <= curF_nxt;
			ch0Freq  <= f0_nxt;
			ch1Freq  <= f1_nxt;
			channel_generation_select <= gen_nxt;
			activeLed <= led_nxt;
			listRunning <= run_nxt;
			reinit_cmd <= reinit_nxt;
			resp     <= resp_nxt;
			st_r     <= st_nxt;
		end
	end

	// ==================================================
	// assertions
	property p_led_on;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && !cmd.isRead && cmd.addr == CMD_ACTIVE && cmd.data[0]
			|=> activeLed;
	endproperty
	a_led_on: assert property (p_led_on) else $error("led not on");
	property p_led_off;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && !cmd.isRead && cmd.addr == CMD_ACTIVE && !cmd.data[0]
			|=> !activeLed;
	endproperty
	a_led_off: assert property (p_led_off) else $error("led not off");
	property p_read_ans;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && cmd.isRead |=> resp.valid;
	endproperty
	a_read_ans: assert property (p_read_ans) else $error("no answer");
	property p_dwell;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && !cmd.isRead && cmd.addr == CMD_DWELL
			|=> dwell_r == $past(cmd.data[31:0]);
	endproperty
	a_dwell: assert property (p_dwell) else $error("dwell not set");
	property p_init0;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && !cmd.isRead && cmd.addr == CMD_REINIT && !cmd.data[0]
			|=> dwell_r == DEF_DWELL && cfg_r == DEF_CFG && !listRunning;
	endproperty
	a_init0: assert property (p_init0) else $error("no defaults");
	property p_init1;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && !cmd.isRead && cmd.addr == CMD_REINIT && cmd.data[0]
			|=> $stable(dwell_r) && $stable(startF_r) && reinit_cmd;
	endproperty
	a_init1: assert property (p_init1) else $error("settings lost");
	property p_zero_pos;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && !cmd.isRead && cmd.addr == CMD_BUF_WRITE
			&& cmd.data == '0 |=> wrPos_r == '0;
	endproperty
	a_zero_pos: assert property (p_zero_pos) else $error("pos kept");
	property p_end_mark;
		@(posedge clk_sys) disable iff (rst)
		cmd.valid && !cmd.isRead && cmd.addr == CMD_BUF_WRITE
			&& cmd.data == BUF_END_MARK
			|=> points_r == 32'($past(wrPos_r)) && $stable(wrPos_r);
	endproperty
	a_end_mark: assert property (p_end_mark) else $error("bad end");
	property p_trig_gate;
		@(posedge clk_sys) disable iff (rst)
		st_r == IDLE && cfg_r[CFG_HWTRIG_BIT] |=> st_r == IDLE;
	endproperty
	a_trig_gate: assert property (p_trig_gate) else $error("hw start");
	property p_hold;
		@(posedge clk_sys) disable iff (rst)
		$fell(listRunning) && !$past(reinit_cmd) && !reinit_cmd
			&& $stable(channel_generation_select) |-> $stable(ch0Freq);
	endproperty
	a_hold: assert property (p_hold) else $error("freq moved");
	c_run: cover property (@(posedge clk_sys) $rose(listRunning));
	c_stop: cover property (@(posedge clk_sys) $fell(listRunning));
	c_load: cover property (@(posedge clk_sys) bufWe);
endmodule // list_sweep_command_engine
`default_nettype wire

// >>> tb/host_model.sv
// host driver model that issues command words to the engine
`default_nettype none
module host_model (
	input  wire logic                  clk_sys, // system clock
	input  wire list_sweep_pkg::resp_s resp,    // answer from engine
	output var  list_sweep_pkg::cmd_s  cmd      // command toward engine
);
	timeunit 1ns;
	timeprecision 1ps;
	import list_sweep_pkg::*;

	// ==================================================
	// bus idle from time zero
	initial begin
		cmd = '0;
	end

	// ==================================================
	// request cycle: one address byte and one word, one clock long
	// address byte plus word
	task automatic issue(input logic isRd, input logic [7:0] a,
		input logic [63:0] d);
		@(posedge clk_sys);
		cmd <= '{valid: 1'b1, isRead: isRd, addr: a, data: d};
		@(posedge clk_sys);
		// released lines show the inverse, never a stale copy
		cmd <= '{valid: 1'b0, isRead: ~isRd, addr: ~a, data: ~d};
	endtask

	// register write
	task automatic wr(input logic [7:0] a, input logic [63:0] d);
		issue(1'b0, a, d);
	endtask

	// register read: the answer stands 1 ns after the take edge
	// received word capture
	task automatic rd(input logic [7:0] a, input logic [63:0] d,
		output logic [63:0] q, output logic ok);
		issue(1'b1, a, d);
		#1;
		ok = resp.valid;
		q  = resp.data;
	endtask
endmodule // host_model
`default_nettype wire

// >>> tb/list_sweep_command_engine_tb.sv
// self-checking bench for the list/sweep command engine
`default_nettype none
module list_sweep_command_engine_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import list_sweep_pkg::*;

	// ==================================================
	// bench signals
	logic        clk_sys;     // 25 MHz clock
	logic        rst;         // sync reset
	cmd_s        cmd;         // host command
	resp_s       resp;        // engine answer
	logic        activeLed;   // indicator
	logic [63:0] ch0Freq;     // channel 0 tuning
	logic [63:0] ch1Freq;     // channel 1 tuning
	logic [1:0]  genSel;      // per-channel mode
	logic        listRunning; // stepping flag
	logic        reinitPulse; // reinit strobe
	int          err_count;   // mismatches
	int          tests_run;   // comparisons
	int          i;           // loop index
	logic [63:0] vals[$];     // values seen in a run, one per change
	int          lens[$];     // cycles each value stood
	logic [63:0] bufVal[3] = '{64'h1111, 64'h2222, 64'h3333};
	logic [63:0] pv[6] = '{64'h64, 64'h82, 64'h0A, 64'h2, 64'h2, 64'h3};

	// ==================================================
	// partner and design
	host_model host_model_inst (
		.clk_sys (clk_sys),
		.resp    (resp),
		.cmd     (cmd)
	);
	list_sweep_command_engine #(
		.UNIT_CYC (4)
	) list_sweep_command_engine_inst (
		.clk_sys                   (clk_sys),
		.rst                       (rst),
		.cmd                       (cmd),
		.resp                      (resp),
		.activeLed                 (activeLed),
		.ch0Freq                   (ch0Freq),
		.ch1Freq                   (ch1Freq),
		.channel_generation_select (genSel),
		.listRunning               (listRunning),
		.reinit_cmd                (reinitPulse)
	);

	// clock generator, 40 ns period
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ==================================================
	// helpers
	task automatic final_report();
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// read and compare, answer strobe included
	task automatic rdChk(input logic [7:0] a, input logic [63:0] d,
		input logic [63:0] exp);
		logic [63:0] q;
		logic        ok;
		host_model_inst.rd(a, d, q, ok);
		chk({63'h0, ok}, 64'h1, "answer strobe");
		chk(q, exp, "read data");
	endtask

	// write, then let the update land
	task automatic put(input logic [7:0] a, input logic [63:0] d);
		host_model_inst.wr(a, d);
		@(negedge clk_sys);
	endtask

	// reinit command followed by its strobe within three cycles
	task automatic reinit(input logic [63:0] mode);
		logic seen;
		seen = 1'b0;
		host_model_inst.wr(CMD_REINIT, mode);
		repeat (3) begin
			@(negedge clk_sys);
			seen = seen | (reinitPulse === 1'b1);
		end
		chk({63'h0, seen}, 64'h1, "reinit strobe");
	endtask

	// trigger, then log channel 0 values until stepping ends
	task automatic watch(input int bound);
		logic [63:0] last;
		logic        seen;
		int          n;
		vals.delete();
		lens.delete();
		seen = 1'b0;
		last = '0;
		put(CMD_SOFT_TRIG, 64'h0);
		for (n = 0; n < bound; n++) begin
			@(negedge clk_sys);
			if (listRunning === 1'b1) begin
				if (!seen || ch0Freq !== last) begin
					vals.push_back(ch0Freq);
					lens.push_back(0);
				end
				lens[lens.size() - 1]++;
				seen = 1'b1;
				last = ch0Freq;
			end else if (seen) begin
				break;
			end
		end
		if (n == bound) begin
			err_count++;
			$display("BAD %0t stepping did not end", $time);
			final_report();
		end
	endtask

	// ==================================================
	// main sequence
	initial begin
		rst = 1'b1;
		err_count = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk(ch0Freq, DEF_FREQ, "ch0 after reset");
		rdChk(CMD_GET_PARAMS, 64'h5, {32'h0, DEF_DWELL});
		put(CMD_ACTIVE, 64'h1);
		chk({63'h0, activeLed}, 64'h1, "indicator on");
		rdChk(CMD_GET_STATUS, 64'h0, 64'h4000);
		put(CMD_ACTIVE, 64'h0);
		chk({63'h0, activeLed}, 64'h0, "indicator off");
		put(CMD_RF_FREQ, 64'h1234);
		chk(ch0Freq, 64'h1234, "ch0 tune");
		put(CMD_RF_FREQ, {1'b1, 63'h5678});
		chk(ch1Freq, 64'h5678, "ch1 tune");
		// sweep parameters; the point count stays within the loaded list
		for (i = 0; i < 6; i++) put(CMD_START_FREQ + 8'(i), pv[i]);
		for (i = 0; i < 6; i++) rdChk(CMD_GET_PARAMS, 64'(i + 2), pv[i]);
		// sequential list load with a position reset part way
		put(CMD_BUF_WRITE, 64'h0);
		put(CMD_BUF_WRITE, 64'h9999);
		put(CMD_BUF_WRITE, 64'h0);
		for (i = 0; i < 3; i++) put(CMD_BUF_WRITE, bufVal[i]);
		put(CMD_BUF_WRITE, BUF_END_MARK);
		rdChk(CMD_GET_PARAMS, 64'h7, 64'h3);
		for (i = 0; i < 3; i++) rdChk(CMD_BUF_WRITE, 64'(i), bufVal[i]);
		// list run, two cycles, dwell 2 units of 4 clocks
		put(CMD_RF_FREQ, bufVal[0]);
		put(CMD_LIST_CONFIG, 64'h0);
		put(CMD_GEN_SELECT, 64'h1);
		watch(300);
		for (i = 0; i < 6; i++) chk(vals[i], bufVal[i % 3], "list point");
		chk(64'(vals.size()), 64'h6, "list length");
		chk(64'(lens[1]), 64'h8, "dwell cycles");
		repeat (3) @(negedge clk_sys);
		chk(ch0Freq, bufVal[2], "held value");
		// trigger refused with hardware source or all channels fixed
		put(CMD_LIST_CONFIG, 64'h8);
		put(CMD_SOFT_TRIG, 64'h0);
		repeat (10) @(negedge clk_sys);
		chk({63'h0, listRunning}, 64'h0, "hw source");
		put(CMD_LIST_CONFIG, 64'h0);
		put(CMD_GEN_SELECT, 64'h0);
		put(CMD_SOFT_TRIG, 64'h0);
		repeat (10) @(negedge clk_sys);
		chk({63'h0, listRunning}, 64'h0, "fixed mode");
		// zero cycles repeats until reconfigured
		put(CMD_CYCLES, 64'h0);
		put(CMD_GEN_SELECT, 64'h1);
		put(CMD_SOFT_TRIG, 64'h0);
		repeat (100) @(negedge clk_sys);
		chk({63'h0, listRunning}, 64'h1, "endless run");
		put(CMD_GEN_SELECT, 64'h0);
		for (i = 0; i < 4 && listRunning !== 1'b0; i++) @(negedge clk_sys);
		chk({63'h0, listRunning}, 64'h0, "run stopped");
		// upward sweep 0x64 to 0x78 in steps of 0x0A, one cycle
		put(CMD_CYCLES, 64'h1);
		put(CMD_RF_FREQ, 64'h64);
		put(CMD_LIST_CONFIG, 64'h1);
		put(CMD_GEN_SELECT, 64'h1);
		watch(300);
		for (i = 0; i < 3; i++) chk(vals[i], 64'h64 + 64'(i * 10), "sweep");
		chk(64'(vals.size()), 64'h3, "sweep length");
		// downward sweep 0x82 to 0x6E, one cycle
		put(CMD_RF_FREQ, 64'h82);
		put(CMD_LIST_CONFIG, 64'h3);
		watch(300);
		for (i = 0; i < 3; i++) chk(vals[i], 64'h82 - 64'(i * 10), "down");
		chk(64'(vals.size()), 64'h3, "down length");
		put(CMD_GEN_SELECT, 64'h101);
		chk({62'h0, genSel}, 64'h3, "both channels");
		// reinit keeping settings, then reinit to defaults
		put(CMD_ACTIVE, 64'h1);
		put(CMD_RF_FREQ, 64'h1234);
		reinit(64'h1);
		chk({63'h0, activeLed}, 64'h1, "kept indicator");
		chk(ch0Freq, 64'h1234, "kept tune");
		reinit(64'h0);
		chk({63'h0, activeLed}, 64'h1, "session indicator");
		chk(ch0Freq, DEF_FREQ, "default tune");
		chk({62'h0, genSel}, 64'h0, "default modes");
		rdChk(CMD_GET_PARAMS, 64'h5, {32'h0, DEF_DWELL});
		rdChk(8'h30, 64'h0, 64'h0);
		final_report();
	end
endmodule // list_sweep_command_engine_tb
`default_nettype wire
